/* inc/sscr_pkg.sv */
// Constants and types for the setup configuration register bank
package sscr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int SSCR_NUM_SETUPS = 4;
    localparam int SSCR_ADDR_W = 8;
    localparam int SSCR_DATA_W = 16;
    localparam logic [7:0] SSCR_ADDR_SETUP0 = 8'h20;
    localparam logic [7:0] SSCR_ADDR_SETUP1 = 8'h21;
    localparam logic [7:0] SSCR_ADDR_SETUP2 = 8'h22;
    localparam logic [7:0] SSCR_ADDR_SETUP3 = 8'h23;
    localparam logic [15:0] SSCR_RESET_VALUE = 16'h1000;
    // Writable bits 12..7 and 5..4; everything else is reserved zero
    localparam logic [15:0] SSCR_WRITE_MASK = 16'h1fb0;
    localparam logic [15:0] SSCR_READ_UNMAPPED = 16'h0000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SSCR_BIT_CODING = 12;
    localparam int SSCR_BIT_REF_BUF_P = 11;
    localparam int SSCR_BIT_REF_BUF_N = 10;
    localparam int SSCR_BIT_IN_BUF_P = 9;
    localparam int SSCR_BIT_IN_BUF_N = 8;
    localparam int SSCR_BIT_BURNOUT = 7;
    localparam int SSCR_BIT_REF_SEL_HI = 5;
    localparam int SSCR_BIT_REF_SEL_LO = 4;

    // ----------------------------------------------------------------
    // Reference source codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SSCR_REF_EXTERNAL = 2'h0;
    localparam logic [1:0] SSCR_REF_RESERVED = 2'h1;
    localparam logic [1:0] SSCR_REF_INTERNAL = 2'h2;
    localparam logic [1:0] SSCR_REF_SUPPLY = 2'h3;

    // Open-wire current magnitude, microamps, for the analog side
    localparam int SSCR_BURNOUT_CURRENT_UA = 10;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic output_coding_select;
        logic pos_ref_buffer_en;
        logic neg_ref_buffer_en;
        logic pos_input_buffer_en;
        logic neg_input_buffer_en;
        logic open_wire_current_en;
        logic [1:0] reference_source_select;
    } sscr_setup_s;

    typedef struct packed {
        logic use_external;
        logic use_internal;
        logic use_supply;
        logic use_reserved;
    } sscr_ref_route_s;

endpackage : sscr_pkg

/* src/sscr_setup_reg.sv */
// One setup configuration register with reserved bits forced to zero
`timescale 1ns/1ps
`default_nettype none
module sscr_setup_reg
    import sscr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [15:0] wdata,
    output logic [15:0] value,
    output sscr_setup_s cfg
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [15:0] value_r;
    logic [15:0] value_nxt;

    // Reserved bits never stored, so they always read zero
    assign value_nxt = wdata & SSCR_WRITE_MASK;

    always_ff @(posedge clk) begin
        if (srst) begin
            value_r <= SSCR_RESET_VALUE;
        end else if (ce && wr_en) begin
            value_r <= value_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Field breakout
    // ----------------------------------------------------------------
    assign value = value_r;
    assign cfg.output_coding_select = value_r[SSCR_BIT_CODING];
    assign cfg.pos_ref_buffer_en = value_r[SSCR_BIT_REF_BUF_P];
    assign cfg.neg_ref_buffer_en = value_r[SSCR_BIT_REF_BUF_N];
    assign cfg.pos_input_buffer_en = value_r[SSCR_BIT_IN_BUF_P];
    assign cfg.neg_input_buffer_en = value_r[SSCR_BIT_IN_BUF_N];
    assign cfg.open_wire_current_en = value_r[SSCR_BIT_BURNOUT];
    assign cfg.reference_source_select =
        value_r[SSCR_BIT_REF_SEL_HI:SSCR_BIT_REF_SEL_LO];

endmodule : sscr_setup_reg
`default_nettype wire

/* src/sscr_regs.sv */
// Setup configuration register bank: four setups behind the register port
//
// Behaviour
// - Bit 10 clear turns the negative reference buffer off, set turns it on.
// - Bit 9 enables the positive analog input buffer when set.
// - Bit 8 enables the negative analog input buffer when set.
// - Bit 7 turns on 10 uA source on positive input, sink on negative.
// - Bits 5:4 pick external (00), internal 2.5 V (10) or supply (11).
// - Bits 15:13, 6 and 3:0 read zero; software writes zero there.
// - Setups one to three at 0x21..0x23, reset 0x1000, same layout.
// - Upper byte: coding, ref buffers, input buffers; lower: burnout, ref select.
// - Bit 12 clear gives unipolar, set gives offset binary; resets to one.
// - Bit 11 enables the positive reference buffer; resets to zero.
// - Setup zero at 0x20 resets to 0x1000.
`timescale 1ns/1ps
`default_nettype none
module sscr_regs
    import sscr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_hit,
    input wire logic [1:0] active_setup,
    output sscr_setup_s [SSCR_NUM_SETUPS-1:0] setup_cfg,
    output sscr_setup_s active_cfg,
    output sscr_ref_route_s active_ref,
    output logic internal_ref_needed
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic [SSCR_NUM_SETUPS-1:0] sel;
    logic [15:0] reg_value [SSCR_NUM_SETUPS];
    logic [1:0] sel_index;
    logic any_sel;

    assign sel[0] = (reg_addr == SSCR_ADDR_SETUP0);
    assign sel[1] = (reg_addr == SSCR_ADDR_SETUP1);
    assign sel[2] = (reg_addr == SSCR_ADDR_SETUP2);
    assign sel[3] = (reg_addr == SSCR_ADDR_SETUP3);
    assign any_sel = |sel;
    assign reg_hit = any_sel;
    // The map is contiguous, so the low address bits index the bank
    assign sel_index = reg_addr[1:0];

    // ----------------------------------------------------------------
    // Register instances
    // ----------------------------------------------------------------
    for (genvar i = 0; i < SSCR_NUM_SETUPS; i++) begin : g_setup
        sscr_setup_reg u_setup (
            .clk(clk),
            .srst(srst),
            .ce(ce),
            .wr_en(reg_wr && sel[i]),
            .wdata(reg_wdata),
            .value(reg_value[i]),
            .cfg(setup_cfg[i])
        );
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic rd_valid_r;

    // Unmapped addresses read zero rather than aliasing a setup
    assign rdata_nxt = any_sel ? reg_value[sel_index] : SSCR_READ_UNMAPPED;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else if (ce) begin
            rd_valid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rd_valid = rd_valid_r;

    // ----------------------------------------------------------------
    // Active setup and reference routing
    // ----------------------------------------------------------------
    sscr_setup_s active_cfg_r;
    sscr_setup_s active_cfg_nxt;
    sscr_ref_route_s active_ref_r;
    sscr_ref_route_s active_ref_nxt;
    logic int_ref_r;
    logic int_ref_nxt;
    logic [SSCR_NUM_SETUPS-1:0] wants_int;

    assign active_cfg_nxt = setup_cfg[active_setup];

    // Code 01 raises only use_reserved; no external, internal or supply reference is chosen
    assign active_ref_nxt.use_external =
        (active_cfg_nxt.reference_source_select == SSCR_REF_EXTERNAL);
    assign active_ref_nxt.use_internal =
        (active_cfg_nxt.reference_source_select == SSCR_REF_INTERNAL);
    assign active_ref_nxt.use_supply =
        (active_cfg_nxt.reference_source_select == SSCR_REF_SUPPLY);
    assign active_ref_nxt.use_reserved =
        (active_cfg_nxt.reference_source_select == SSCR_REF_RESERVED);

    for (genvar j = 0; j < SSCR_NUM_SETUPS; j++) begin : g_int_ref
        assign wants_int[j] = (setup_cfg[j].reference_source_select == SSCR_REF_INTERNAL);
    end
    // Hint for mode logic only; enabling the reference stays with software
    assign int_ref_nxt = |wants_int;

    always_ff @(posedge clk) begin
        if (srst) begin
            active_cfg_r <= {SSCR_RESET_VALUE[12:7], SSCR_RESET_VALUE[5:4]};
            active_ref_r <= '{use_external: 1'b1, default: 1'b0};
            int_ref_r <= 1'b0;
        end else if (ce) begin
            active_cfg_r <= active_cfg_nxt;
            active_ref_r <= active_ref_nxt;
            int_ref_r <= int_ref_nxt;
        end
    end

    assign active_cfg = active_cfg_r;
    assign active_ref = active_ref_r;
    assign internal_ref_needed = int_ref_r;

endmodule : sscr_regs
`default_nettype wire

/* dv/sscr_regs_properties.sv */
// Port checks for the setup register bank
`timescale 1ns/1ps
`default_nettype none
module sscr_regs_chk
    import sscr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_hit,
    input wire logic [1:0] active_setup,
    input wire sscr_setup_s [SSCR_NUM_SETUPS-1:0] setup_cfg,
    input wire sscr_setup_s active_cfg,
    input wire sscr_ref_route_s active_ref,
    input wire logic internal_ref_needed
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    logic [7:0] wr_cfg;
    logic [1:0] wr_idx;
    sscr_setup_s sel_cfg;
    assign wr_cfg = {reg_wdata[12:7], reg_wdata[5:4]};
    assign wr_idx = reg_addr[1:0];
    assign sel_cfg = setup_cfg[active_setup];
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_rd_answer: assert property (ce && reg_rd |=> reg_rd_valid)
        else $error("read not answered");
    a_rd_idle: assert property (ce && !reg_rd |=> !reg_rd_valid)
        else $error("spurious read valid");
    a_hit_decode: assert property (reg_hit == (reg_addr[7:2] == 6'h08))
        else $error("hit decode wrong");
    a_reserved_zero: assert property (reg_rd_valid |-> (reg_rdata & ~SSCR_WRITE_MASK) == 0)
        else $error("reserved bit set");
    a_unmapped_zero: assert property (ce && reg_rd && !reg_hit |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_write_lands: assert property (ce && reg_wr && reg_hit |=>
        setup_cfg[$past(wr_idx)] == $past(wr_cfg))
        else $error("write not stored");
    a_active_copy: assert property (ce |=> active_cfg == $past(sel_cfg))
        else $error("active copy wrong");
    a_ref_route: assert property (active_ref == {active_cfg.reference_source_select == 2'h0,
        active_cfg.reference_source_select == 2'h2, active_cfg.reference_source_select == 2'h3,
        active_cfg.reference_source_select == 2'h1}) else $error("route decode wrong");
    a_reset_vals: assert property ($fell(srst) |-> setup_cfg == {4{8'h80}})
        else $error("reset values wrong");
    a_ce_freeze: assert property (!ce |=> $stable(setup_cfg) && $stable(reg_rd_valid)
        && $stable(reg_rdata))
        else $error("state moved with ce low");
endmodule : sscr_regs_chk
bind sscr_regs sscr_regs_chk i_chk (.*);
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the setup register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sscr_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_rd = 1'b0;
    logic [1:0] active_setup = 2'h0;
    logic [15:0] reg_rdata;
    logic reg_rd_valid;
    logic reg_hit;
    sscr_setup_s [SSCR_NUM_SETUPS-1:0] setup_cfg;
    sscr_setup_s active_cfg;
    sscr_ref_route_s active_ref;
    logic internal_ref_needed;
    logic [15:0] mdl [4] = '{4{16'h1000}};
    logic [15:0] exp_q [$];
    logic [15:0] seed = 16'h000f;
    logic [15:0] t;
    logic [15:0] d;
    logic ce_seen = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    sscr_regs i_dut (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit), .active_setup(active_setup),
        .setup_cfg(setup_cfg), .active_cfg(active_cfg), .active_ref(active_ref),
        .internal_ref_needed(internal_ref_needed));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    // Model updated after the read note, so same-cycle reads see the old value
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d,
                      input logic c);
        logic [15:0] s;
        @(posedge clk);
        s = rnd();
        ce <= c;
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        active_setup <= s[1:0];
        if (c && r) exp_q.push_back(a[7:2] == 6'h08 ? mdl[a[1:0]] : 16'h0000);
        if (c && w && a[7:2] == 6'h08) mdl[a[1:0]] = d & SSCR_WRITE_MASK;
    endtask : op
    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        // Valid is held, not renewed, while ce is low
        if (reg_rd_valid === 1'b1 && ce_seen === 1'b1) begin
            if (exp_q.size() == 0) check(reg_rdata, 16'hdead);
            else check(reg_rdata, exp_q.pop_front());
        end
        ce_seen <= ce;
    end
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) op(0, 1, 8'h1f + 8'(i), 16'h0000, 1);
        op(1, 1, 8'h21, 16'h1fb0, 1);
        op(0, 1, 8'h21, 16'h0000, 1);
        // Code 01 never written, so setup one takes the supply code
        for (int k = 0; k < 4; k++) op(1, 1, 8'h20 + 8'(k), 16'((k == 1 ? 3 : k) << 4), 1);
        repeat (3) op(0, 0, 8'h00, 16'h0000, 1);
        @(negedge clk);
        check(16'(internal_ref_needed), 16'h0001);
        // Random mix, ce mostly high, unmapped neighbours included
        for (int n = 0; n < 400; n++) begin
            t = rnd();
            d = rnd() & SSCR_WRITE_MASK;
            if (d[5:4] == SSCR_REF_RESERVED) d[5:4] = SSCR_REF_EXTERNAL;
            // Open-wire currents only now and then, between measurements
            if (n % 50 != 0) d[7] = 1'b0;
            op(t[0], t[1], 8'h1e + 8'(t[4:2]), d, t[7:5] != 3'h0);
        end
        repeat (2) op(0, 0, 8'h00, 16'h0000, 1);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        mdl = '{4{16'h1000}};
        for (int i = 0; i < 4; i++) op(0, 1, 8'h20 + 8'(i), 16'h0000, 1);
        op(0, 0, 8'h00, 16'h0000, 1);
        for (int n = 0; n < 10 && exp_q.size() > 0; n++) @(posedge clk);
        if (exp_q.size() > 0) num_errors++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
